//--- shared/fmc_pkg.sv
package fmc_pkg;

  // Clock period in picoseconds at 20 MHz
  localparam int CLK_PERIOD_PS    = 50000;
  // Least strobe active time, recovery time and setup lead, in ns
  localparam int CYC_ACTIVE_NS    = 120;
  localparam int CYC_RECOVER_NS   = 90;
  localparam int CTL_SETUP_NS     = 30;
  localparam int PARERR_VALID_NS  = 135;
  // Average refresh interval in ns
  localparam int REFRESH_NS       = 16000;
  // Least times round up, longest round down
  localparam int CYC_ACTIVE_CYC   =
    (CYC_ACTIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_RECOVER_CYC  =
    (CYC_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CTL_SETUP_CYC    =
    (CTL_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PARERR_CYC       =
    (PARERR_VALID_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFRESH_CYC      = (REFRESH_NS * 1000) / CLK_PERIOD_PS;

  localparam int ADDR_W           = 23;
  localparam int DATA_W           = 32;
  localparam int CNT_W            = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

  // Cycle kinds; CPU and VME requested by the user, refresh by the timer
  localparam logic [1:0] KIND_CPU = 2'h0;
  localparam logic [1:0] KIND_VME = 2'h1;
  localparam logic [1:0] KIND_REF = 2'h2;

  // Gray-coded sequence: idle, setup, active, recovery
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_SETUP   = 2'h1,
    ST_ACTIVE  = 2'h3,
    ST_RECOVER = 2'h2
  } fmc_state_t;

endpackage

//--- src/fmc_host.sv
`timescale 1ns/1ps
module fmc_host
  import fmc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              clkEn,
  // User request side
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic [1:0]        reqKind,
  input  wire logic              reqWrite,
  input  wire logic              reqLongword,
  input  wire logic              reqUpper,
  input  wire logic              reqLower,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspRdata,
  output logic                   rspParityErr,
  output logic                   refreshDue,
  // Fast memory bus pins
  output logic                   cycle_strobe_n,
  output logic                   vmebus_cycle_n,
  output logic                   refresh_cycle_n,
  output logic                   mem_write_n,
  output logic                   mem_longword_n,
  output logic                   mem_upper_strobe_n,
  output logic                   mem_lower_strobe_n,
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic [DATA_W-1:0] memDataIn,
  output logic [DATA_W-1:0]      memDataOut,
  output logic                   memDataOe,
  input  wire logic              parity_error_n
);

  typedef struct packed {
    fmc_state_t        state;
    logic [CNT_W-1:0]  timer;
    logic [CNT_W-1:0]  refTimer;
    logic              refPending;
    logic [1:0]        kind;
    logic              write;
    logic              longword;
    logic              upper;
    logic              lower;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              oe;
    logic              rspValid;
    logic [DATA_W-1:0] rdata;
    logic              perr;
  } fmc_regs_t;

  fmc_regs_t s_reg;
  fmc_regs_t s_next;

  // Sampling point for read data, just before the strobe drops
  localparam logic [CNT_W-1:0] ACTIVE_LAST = CNT_W'(CYC_ACTIVE_CYC - 1);
  localparam logic [CNT_W-1:0] SAMPLE_AT   = CNT_W'(PARERR_CYC - 1);

  // Handshake: new cycles only from idle; refresh takes priority
  assign reqReady = (s_reg.state == ST_IDLE) && !s_reg.refPending
                    && (reqKind != KIND_REF);

  // Next-state logic for the whole controller
  always_comb
  begin
    s_next = s_reg;
    s_next.rspValid = 1'b0;
    // Average refresh pacing, pending flag set wins over clear
    if (s_reg.refTimer == CNT_W'(REFRESH_CYC - 1))
    begin
      s_next.refTimer = CNT_ZERO;
      s_next.refPending = 1'b1;
    end
    else
    begin
      s_next.refTimer = s_reg.refTimer + CNT_W'(1);
    end
    case (s_reg.state)
      ST_IDLE:
      begin
        // Only one cycle ever reaches the device at a time
        if (s_reg.refPending)
        begin
          s_next.kind = KIND_REF;
          s_next.write = 1'b0;
          s_next.oe = 1'b0;
          s_next.timer = CNT_ZERO;
          s_next.state = ST_SETUP;
          if (s_reg.refTimer != CNT_W'(REFRESH_CYC - 1))
          begin
            s_next.refPending = 1'b0;
          end
        end
        else if (reqValid && reqReady)
        begin
          s_next.kind = reqKind;
          s_next.write = reqWrite;
          s_next.longword = reqLongword;
          s_next.upper = reqUpper;
          s_next.lower = reqLower;
          s_next.addr = reqAddr;
          s_next.wdata = reqWdata;
          // Bus cycles move data on the VMEbus, not on this data path
          s_next.oe = reqWrite && (reqKind == KIND_CPU);
          s_next.timer = CNT_ZERO;
          s_next.state = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // Indicators and address lead the strobe by the setup time
        if (s_reg.timer == CNT_W'(CTL_SETUP_CYC - 1))
        begin
          s_next.timer = CNT_ZERO;
          s_next.state = ST_ACTIVE;
        end
        else
        begin
          s_next.timer = s_reg.timer + CNT_W'(1);
        end
      end
      ST_ACTIVE:
      begin
        // Parity error is valid only late in the cycle
        if (s_reg.timer == SAMPLE_AT && !s_reg.write
            && s_reg.kind == KIND_CPU)
        begin
          s_next.rdata = memDataIn;
          s_next.perr = !parity_error_n;
        end
        // Strobe held long enough for both active and parity times
        if (s_reg.timer >= ACTIVE_LAST && s_reg.timer >= SAMPLE_AT)
        begin
          s_next.timer = CNT_ZERO;
          s_next.oe = 1'b0;
          s_next.state = ST_RECOVER;
          s_next.rspValid = (s_reg.kind != KIND_REF);
        end
        else
        begin
          s_next.timer = s_reg.timer + CNT_W'(1);
        end
      end
      ST_RECOVER:
      begin
        if (s_reg.timer == CNT_W'(CYC_RECOVER_CYC - 1))
        begin
          s_next.state = ST_IDLE;
          s_next.timer = CNT_ZERO;
        end
        else
        begin
          s_next.timer = s_reg.timer + CNT_W'(1);
        end
      end
      default:
      begin
        s_next.state = ST_IDLE;
      end
    endcase
    if (s_reg.state == ST_IDLE && s_next.state == ST_SETUP)
    begin
      s_next.perr = 1'b0;
      s_next.rdata = '0;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
    end
    else if (clkEn)
    begin
      s_reg <= s_next;
    end
  end

  // Pin drive; controls held stable from setup through recovery
  assign cycle_strobe_n     = !(s_reg.state == ST_ACTIVE);
  assign vmebus_cycle_n     = !((s_reg.state != ST_IDLE)
                                && s_reg.kind == KIND_VME);
  assign refresh_cycle_n    = !((s_reg.state != ST_IDLE)
                                && s_reg.kind == KIND_REF);
  assign mem_write_n        = !s_reg.write;
  assign mem_longword_n     = !s_reg.longword;
  assign mem_upper_strobe_n = !s_reg.upper;
  assign mem_lower_strobe_n = !s_reg.lower;
  assign mem_addr           = s_reg.addr;
  assign memDataOut         = s_reg.wdata;
  assign memDataOe          = s_reg.oe;
  assign rspValid           = s_reg.rspValid;
  assign rspRdata           = s_reg.rdata;
  assign rspParityErr       = s_reg.perr;
  assign refreshDue         = s_reg.refPending;

  // Strobe active time is at least the documented minimum
  property p_active_len;
    @(posedge mclk) disable iff (!nrst || !clkEn)
      $fell(cycle_strobe_n) |-> !cycle_strobe_n [*3];
  endproperty
  a_active_len: assert property (p_active_len)
    else $error("cycle strobe too short");

  // Recovery between strobes
  property p_recover;
    @(posedge mclk) disable iff (!nrst || !clkEn)
      $rose(cycle_strobe_n) |-> cycle_strobe_n [*2];
  endproperty
  a_recover: assert property (p_recover)
    else $error("recovery time too short");

  // Indicator settled before strobe asserts
  property p_setup;
    @(posedge mclk) disable iff (!nrst || !clkEn)
      $fell(cycle_strobe_n) |-> $stable(vmebus_cycle_n)
        && $stable(refresh_cycle_n) && $stable(mem_addr);
  endproperty
  a_setup: assert property (p_setup)
    else $error("controls changed at strobe");

  // Controls stable throughout the active part
  property p_stable;
    @(posedge mclk) disable iff (!nrst || !clkEn)
      !cycle_strobe_n && !$fell(cycle_strobe_n) |->
        $stable(mem_addr) && $stable(mem_write_n)
        && $stable(vmebus_cycle_n) && $stable(refresh_cycle_n);
  endproperty
  a_stable: assert property (p_stable)
    else $error("controls changed during cycle");

  // Never both indicators at once
  property p_one_kind;
    @(posedge mclk) disable iff (!nrst)
      !(!vmebus_cycle_n && !refresh_cycle_n);
  endproperty
  a_one_kind: assert property (p_one_kind)
    else $error("two cycle kinds at once");

  // Pending refresh is started within a bounded time
  property p_refresh;
    @(posedge mclk) disable iff (!nrst || !clkEn)
      $rose(refreshDue) |-> ##[1:30] !refresh_cycle_n;
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh not started");

endmodule

//--- verification/fmc_mem.sv
`timescale 1ns/1ps
// Behavioural memory board that answers the fast bus pins
module fmc_mem
  import fmc_pkg::*;
#(
  parameter logic [2:0] WIN = 3'h0,
  parameter bit         CHK = 1'b1
)
(
  input  wire logic              mclk,
  input  wire logic              cycle_strobe_n,
  input  wire logic              vmebus_cycle_n,
  input  wire logic              refresh_cycle_n,
  input  wire logic              mem_write_n,
  input  wire logic              mem_longword_n,
  input  wire logic              mem_upper_strobe_n,
  input  wire logic              mem_lower_strobe_n,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] memData,
  input  wire logic              flipPar,
  output logic      [DATA_W-1:0] memDataIn = 32'h0,
  output logic                   parity_error_n = 1'h1,
  output logic      [7:0]        refCount = 8'h00,
  output int                     nViol = 0
);
  // Sparse store: 32 data bits and 4 parity bits per word
  logic [35:0] arr [int];
  logic [35:0] w;
  logic [3:0]  m;
  logic [1:0]  ind;
  logic        sPrev = 1'h1;
  logic        cpu;
  int          lo = 0;
  int          hi = 9;

  function automatic logic [3:0] lane_mask(logic lw, u, l, a1);
    if (lw && !u && !l) return 4'hF;
    if (u && l) return a1 ? 4'h3 : 4'hC;
    if (u) return a1 ? 4'h1 : 4'h4;
    if (l) return a1 ? 4'h2 : 4'h8;
    return 4'h0;
  endfunction

  // Bus cycles carry data over the backplane, not modelled here
  assign cpu = vmebus_cycle_n && refresh_cycle_n
               && mem_addr[22:20] == WIN;

  // Pin timing is judged per edge, so the clock grain is the tolerance
  always @(posedge mclk)
  begin
    sPrev <= cycle_strobe_n;
    if (!cycle_strobe_n && sPrev)
    begin
      if (hi < CYC_RECOVER_CYC) nViol <= nViol + 1;
      lo = 0;
      ind = {vmebus_cycle_n, refresh_cycle_n};
      if (!refresh_cycle_n) refCount <= refCount + 8'h01;
      w = arr.exists(int'(mem_addr[19:1])) ? arr[int'(mem_addr[19:1])] : '0;
      if (cpu && mem_write_n)
      begin
        memDataIn <= w[31:0];
        parity_error_n <= !(CHK && ({^w[31:24], ^w[23:16], ^w[15:8],
          ^w[7:0]} != w[35:32]));
      end
    end
    if (!cycle_strobe_n)
    begin
      lo = lo + 1;
      if ({vmebus_cycle_n, refresh_cycle_n} != ind) nViol <= nViol + 1;
      m = lane_mask(!mem_longword_n, !mem_upper_strobe_n,
                    !mem_lower_strobe_n, mem_addr[0]);
      if (lo == 2 && cpu && !mem_write_n)
      begin
        for (int b = 0; b < 4; b++)
          if (m[b]) {w[32+b], w[b*8+:8]} = {^memData[b*8+:8] ^ flipPar,
            memData[b*8+:8]};
        arr[int'(mem_addr[19:1])] = w;
      end
    end
    else
    begin
      if (!sPrev && lo < CYC_ACTIVE_CYC) nViol <= nViol + 1;
      // Released lines show the inverse so stale data is never read
      if (!sPrev) memDataIn <= ~memDataIn;
      if (!sPrev) parity_error_n <= 1'h1;
      hi = sPrev ? hi + 1 : 1;
    end
  end
endmodule

//--- verification/tb_fmc_host.sv
`timescale 1ns/1ps
// Directed and random traffic against a behavioural memory board
module tb_fmc_host
  import fmc_pkg::*;
;
  logic mclk = '0, nrst = '0, clkEn = 1'h1, reqValid = '0, reqWrite = '0;
  logic reqLongword = '0, reqUpper = '0, reqLower = '0, flipPar = '0;
  logic [1:0] reqKind = '0;
  logic [ADDR_W-1:0] reqAddr = '0, mem_addr;
  logic [DATA_W-1:0] reqWdata = '0, rspRdata, memDataIn, memDataOut;
  logic reqReady, rspValid, rspParityErr, refreshDue, cycle_strobe_n;
  logic vmebus_cycle_n, refresh_cycle_n, mem_write_n, mem_longword_n;
  logic mem_upper_strobe_n, mem_lower_strobe_n, memDataOe, parity_error_n;
  logic [7:0] refCount;
  logic [31:0] rs = 32'hBD64DF1B, r, model [int];
  bit bad [int];
  int nViol, n_mismatch = 0, samples_checked = 0, i, n;

  fmc_host u_fmc_host (.*);
  fmc_mem u_fmc_mem (.memData(memDataOut), .*);

  initial forever #25 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(bit ok, string msg);
    samples_checked++;
    if (!ok) n_mismatch++;
    if (!ok) $display("[FAIL] %0t %s", $time, msg);
  endtask

  // Verdict; also where any expired wait lands
  task automatic complete_run();
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic expire(int cnt, int lim);
    if (cnt >= lim) chk(0, "wait expired");
    if (cnt >= lim) complete_run();
  endtask

  // One request: held until taken, then its answer is compared
  task automatic req(logic [1:0] k, logic w, lw, u, l,
                     logic [ADDR_W-1:0] a, logic [31:0] d);
    int c;
    int key;
    logic [3:0] m;
    @(posedge mclk);
    {reqValid, reqKind, reqWrite} <= {1'h1, k, w};
    {reqLongword, reqUpper, reqLower} <= {lw, u, l};
    reqAddr <= a;
    reqWdata <= d;
    key = int'(a[19:1]);
    m = u_fmc_mem.lane_mask(lw, u, l, a[0]);
    @(negedge mclk);
    for (c = 0; reqReady !== 1'h1 && c < 800; c++) @(negedge mclk);
    expire(c, 800);
    @(posedge mclk);
    reqValid <= 1'h0;
    for (c = 0; rspValid !== 1'h1 && c < 60; c++)
    begin
      @(negedge mclk);
      if (cycle_strobe_n === 1'h0)
        chk({vmebus_cycle_n, refresh_cycle_n} === {k != KIND_VME, 1'h1},
            "cycle kind lines");
      if (cycle_strobe_n === 1'h0)
        chk(memDataOe === (k == KIND_CPU && w), "data drive");
    end
    expire(c, 60);
    if (k == KIND_CPU && w && m != 4'h0) bad[key] = flipPar;
    for (int b = 0; b < 4; b++)
      if (k == KIND_CPU && w && m[b]) model[key][b*8+:8] = d[b*8+:8];
    if (k == KIND_CPU && !w)
      chk(rspRdata === model[key], "read data");
    if (k == KIND_CPU && !w)
      chk(rspParityErr === bad[key], "parity flag");
    if (k == KIND_VME) chk(rspRdata === 32'h0, "bus cycle data");
  endtask

  // Reset, then one block of traffic per behaviour
  initial
  begin
    repeat (8) @(posedge mclk);
    nrst <= 1'h1;
    for (i = 0; i < 8; i++) req(KIND_CPU, 1, 1, 0, 0, 23'(i * 2), rnd());
    for (i = 0; i < 8; i++) req(KIND_CPU, 0, 1, 0, 0, 23'(i * 2 + 1), 0);
    $display("longword test done");
    for (i = 0; i < 6; i++)
    begin
      r = 32'(7 - (i ^ 1));
      req(KIND_CPU, 1, 0, r[2], r[1], 23'(r[0]), rnd());
      req(KIND_CPU, 0, 1, 0, 0, 23'h0, 0);
    end
    $display("lane test done");
    req(KIND_CPU, 1, 0, 0, 0, 23'h2, rnd());
    req(KIND_VME, 1, 0, 1, 1, 23'h2, rnd());
    req(KIND_VME, 0, 0, 1, 1, 23'h2, 0);
    req(KIND_CPU, 0, 1, 0, 0, 23'h2, 0);
    $display("illegal and bus test done");
    flipPar <= 1'h1;
    req(KIND_CPU, 1, 1, 0, 0, 23'h6, rnd());
    flipPar <= 1'h0;
    req(KIND_CPU, 0, 1, 0, 0, 23'h6, 0);
    req(KIND_CPU, 1, 1, 0, 0, 23'h6, rnd());
    req(KIND_CPU, 0, 1, 0, 0, 23'h6, 0);
    for (i = 0; i < 16; i++)
    begin
      r = rnd();
      req(KIND_CPU, r[0], 1, 0, 0, 23'(r[3:1] * 2), rnd());
    end
    $display("parity and random test done");
    i = int'(refCount);
    // Pending flag first, then the whole refresh cycle to its end
    for (n = 0; refreshDue !== 1'h1 && n < 700; n++) @(negedge mclk);
    expire(n, 700);
    for (n = 0; refresh_cycle_n !== 1'h0 && n < 40; n++) @(negedge mclk);
    expire(n, 40);
    for (n = 0; refresh_cycle_n !== 1'h1 && n < 40; n++) @(negedge mclk);
    expire(n, 40);
    chk(refCount === 8'(i + 1), "refresh count");
    @(posedge mclk);
    {reqValid, reqKind} <= {1'h1, KIND_REF};
    @(negedge mclk);
    chk(reqReady === 1'h0, "refresh kind taken");
    @(posedge mclk);
    reqValid <= 1'h0;
    chk(nViol === 0, "pin timing");
    $display("refresh test done");
    // Freeze the clock enable mid-strobe; the strobe must stay low
    fork
      req(KIND_CPU, 0, 1, 0, 0, 23'h6, 0);
      begin
        for (n = 0; cycle_strobe_n !== 1'h0 && n < 40; n++) @(negedge mclk);
        expire(n, 40);
        @(posedge mclk);
        clkEn <= 1'h0;
        repeat (6) @(negedge mclk);
        chk(cycle_strobe_n === 1'h0, "clock enable freeze");
        @(posedge mclk);
        clkEn <= 1'h1;
      end
    join
    $display("clock enable test done");
    complete_run();
  end
endmodule
